// file: rgt_pkg.sv
// rgt_pkg: constants and types shared by the reader timer block.
// Assumes word-aligned AHB-Lite access; each register index sits at 4*index.
package rgt_pkg;
  localparam int CNT_W = 16;
  localparam int IRQ_W = 2;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_A_CNT_HI  = 8'h17;
  localparam logic [7:0] IDX_A_CNT_LO  = 8'h18;
  localparam logic [7:0] IDX_B_CTRL    = 8'h19;
  localparam logic [7:0] IDX_B_RL_HI   = 8'h1a;
  localparam logic [7:0] IDX_B_RL_LO   = 8'h1b;
  localparam logic [7:0] IDX_B_CNT_HI  = 8'h1c;
  localparam logic [7:0] IDX_B_CNT_LO  = 8'h1d;
  localparam logic [7:0] IDX_C_CTRL    = 8'h1e;
  localparam logic [7:0] IDX_C_RL_HI   = 8'h1f;
  localparam logic [7:0] IDX_C_RL_LO   = 8'h20;
  localparam logic [7:0] IDX_C_CNT_HI  = 8'h21;
  localparam logic [7:0] IDX_C_CNT_LO  = 8'h22;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h40;
  localparam logic [7:0] IDX_IRQ_EN    = 8'h41;
  localparam logic [7:0] IDX_IRQ_CLR   = 8'h42;
  localparam logic [7:0] IDX_CMD       = 8'h43;
  localparam logic [7:0] IDX_NONE      = 8'hff;
  // Control byte layout
  localparam int CTRL_HALT_BIT  = 7;
  localparam int CTRL_START_LSB = 4;
  localparam int CTRL_AUTO_BIT  = 3;
  localparam int CTRL_CLK_LSB   = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hbb;
  // Interrupt and command bits
  localparam int IRQ_B_BIT    = 0;
  localparam int IRQ_C_BIT    = 1;
  localparam int CMD_B_START  = 0;
  localparam int CMD_B_STOP   = 1;
  localparam int CMD_C_START  = 2;
  localparam int CMD_C_STOP   = 3;
  // Reset values, and the AHB-Lite NONSEQ transfer code
  localparam logic [7:0]       CTRL_RST = 8'h00;
  localparam logic [7:0]       RL_RST   = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    START_NONE = 2'b00, START_TX_END = 2'b01,
    START_TRIM = 2'b10, START_TRIM_UF = 2'b11
  } rgt_start_t;
  typedef enum logic [1:0] {
    CLK_FAST = 2'b00, CLK_SLOW = 2'b01, CLK_T0_UF = 2'b10, CLK_T1_UF = 2'b11
  } rgt_clk_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01, BUS_WDATA = 2'b10
  } rgt_bus_t;
endpackage : rgt_pkg

// file: rgt_timer.sv
// rgt_timer: one 16-bit down counter with start modes and auto-reload.
// Assumes every event and tick on the channel is a single hclk pulse.
module rgt_timer
  import rgt_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  rgt_tmr_if.tmr    ch
);
  typedef struct packed {
    logic             running;
    logic [CNT_W-1:0] count;
    logic             uf;
  } rgt_tmr_state_t;

  rgt_tmr_state_t st_reg;
  rgt_tmr_state_t st_next;
  rgt_start_t     mode;
  rgt_clk_t       sel;
  logic           trim;
  logic           tick;
  logic           start_evt;
  logic           stop_evt;
  logic           zero;

  always_comb begin
    mode = rgt_start_t'(ch.ctrl[CTRL_START_LSB +: 2]);
    sel  = rgt_clk_t'(ch.ctrl[CTRL_CLK_LSB +: 2]);
    trim = (mode == START_TRIM) || (mode == START_TRIM_UF);
    case (sel)
      CLK_FAST:  tick = ch.tick_fast;
      CLK_SLOW:  tick = ch.tick_slow;
      CLK_T0_UF: tick = ch.tick_t0;
      CLK_T1_UF: tick = ch.tick_t1;
      default:   tick = 1'b0;
    endcase
    // Trimming toggles on each oscillator rising edge
    start_evt = ch.sw_start || ((mode == START_TX_END) && ch.tx_end) ||
                (trim && ch.lfo_rise && !st_reg.running);
    stop_evt  = ch.sw_stop ||
                (ch.ctrl[CTRL_HALT_BIT] && !trim &&
                 ch.rx_first4) ||
                (trim && ch.lfo_rise && st_reg.running);
    zero = (st_reg.count == '0);
    st_next    = st_reg;
    st_next.uf = 1'b0;
    if (start_evt) begin
      st_next.running = 1'b1;
      st_next.count   = ch.reload;
    end else if (stop_evt) begin
      st_next.running = 1'b0;
    end else if (st_reg.running && tick) begin
      if (!zero) begin
        st_next.count = st_reg.count - 1'b1;
      end else if (mode == START_TRIM) begin
        // Trimming without underflow ends quietly at zero
        st_next.running = 1'b0;
      end else begin
        st_next.uf = 1'b1;
        if (ch.ctrl[CTRL_AUTO_BIT]) begin
          st_next.count = ch.reload;
        end else begin
          st_next.running = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '{running: 1'b0, count: CNT_RST, uf: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ch.count   = st_reg.count;
  assign ch.running = st_reg.running;
  assign ch.uf      = st_reg.uf;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RX_HALT: assert property (
    st_reg.running && ch.ctrl[CTRL_HALT_BIT] && !trim && ch.rx_first4 &&
    !start_evt |=> !st_reg.running ##1 (!st_reg.running || $past(start_evt))
  ) else $error("timer kept running after first receive bits");
  AST_TRIM_NO_HALT: assert property (
    st_reg.running && trim && ch.rx_first4 && !ch.lfo_rise &&
    !ch.sw_stop && !ch.sw_start && !tick |=> st_reg.running
  ) else $error("halt on receive acted in trimming mode");
  AST_TX_START: assert property (
    (mode == START_TX_END) && ch.tx_end |=>
    st_reg.running && st_reg.count == $past(ch.reload)
  ) else $error("end of transmit did not load and start");
  AST_AUTO_RELOAD: assert property (
    st_reg.running && tick && zero && ch.ctrl[CTRL_AUTO_BIT] &&
    mode != START_TRIM && !start_evt && !stop_evt |=>
    st_reg.running && st_reg.uf && st_reg.count == $past(ch.reload)
  ) else $error("auto reload failed at underflow");
  AST_ONE_SHOT: assert property (
    st_reg.running && tick && zero && !ch.ctrl[CTRL_AUTO_BIT] &&
    mode != START_TRIM && !start_evt && !stop_evt |=>
    !st_reg.running && st_reg.uf ##1 !st_reg.uf
  ) else $error("one shot did not stop with a single underflow");
  AST_DECREMENT: assert property (
    st_reg.running && tick && !zero && !start_evt && !stop_evt |=>
    st_reg.count == $past(st_reg.count) - 16'h0001
  ) else $error("count did not step down on tick");
  AST_HOLD: assert property (
    !start_evt && !(st_reg.running && tick) |=> $stable(st_reg.count)
  ) else $error("count moved without tick or start");
endmodule : rgt_timer

// file: rgt_timers_top.sv
// rgt_timers_top: AHB-Lite register block with timers B and C, timer A
// count readback and a level interrupt.
// Assumes tick, underflow and transmit/receive events are hclk pulses;
// the oscillator input is asynchronous and is synchronised here.
//
// Chosen here: the AHB-Lite slave port.
module rgt_timers_top
  import rgt_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        tx_end,
  input  wire logic        rx_first4_bits,
  input  wire logic        low_freq_oscillator,
  input  wire logic        tick_13m56,
  input  wire logic        tick_212k,
  input  wire logic        tmr0_underflow,
  input  wire logic        tmr1_underflow,
  input  wire logic [15:0] tmr_a_count,
  output logic             tmr_b_underflow,
  output logic             tmr_c_underflow,
  output logic             irq
);
  typedef struct packed {
    rgt_bus_t         bus;
    logic [7:0]       widx;
    logic [31:0]      rdata;
    logic             ready;
    logic             resp;
    logic [7:0]       b_ctrl;
    logic [7:0]       b_rl_hi;
    logic [7:0]       b_rl_lo;
    logic [7:0]       c_ctrl;
    logic [7:0]       c_rl_hi;
    logic [7:0]       c_rl_lo;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic             irq;
    logic             b_start;
    logic             b_stop;
    logic             c_start;
    logic             c_stop;
    logic [2:0]       lfo_sync;
  } rgt_top_state_t;

  localparam rgt_top_state_t TOP_RST = '{
    bus: BUS_IDLE, widx: IDX_NONE, rdata: 32'h0000_0000,
    ready: 1'b1, resp: 1'b0,
    b_ctrl: CTRL_RST, b_rl_hi: RL_RST, b_rl_lo: RL_RST,
    c_ctrl: CTRL_RST, c_rl_hi: RL_RST, c_rl_lo: RL_RST,
    irq_st: '0, irq_en: '0, irq: 1'b0,
    b_start: 1'b0, b_stop: 1'b0, c_start: 1'b0, c_stop: 1'b0,
    lfo_sync: 3'h0
  };

  rgt_top_state_t st_reg;
  rgt_top_state_t st_next;
  logic [7:0]     aidx;
  logic           acc;
  logic           lfo_rise;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  rgt_tmr_if ch_b ();
  rgt_tmr_if ch_c ();

  // Shared events reach both channels alike
  always_comb begin
    lfo_rise = st_reg.lfo_sync[1] && !st_reg.lfo_sync[2];
    ch_b.ctrl      = st_reg.b_ctrl;
    ch_b.reload    = {st_reg.b_rl_hi, st_reg.b_rl_lo};
    ch_b.sw_start  = st_reg.b_start;
    ch_b.sw_stop   = st_reg.b_stop;
    ch_b.tx_end    = tx_end;
    ch_b.rx_first4 = rx_first4_bits;
    ch_b.lfo_rise  = lfo_rise;
    ch_b.tick_fast = tick_13m56;
    ch_b.tick_slow = tick_212k;
    ch_b.tick_t0   = tmr0_underflow;
    ch_b.tick_t1   = tmr1_underflow;
    ch_c.ctrl      = st_reg.c_ctrl;
    ch_c.reload    = {st_reg.c_rl_hi, st_reg.c_rl_lo};
    ch_c.sw_start  = st_reg.c_start;
    ch_c.sw_stop   = st_reg.c_stop;
    ch_c.tx_end    = tx_end;
    ch_c.rx_first4 = rx_first4_bits;
    ch_c.lfo_rise  = lfo_rise;
    ch_c.tick_fast = tick_13m56;
    ch_c.tick_slow = tick_212k;
    ch_c.tick_t0   = tmr0_underflow;
    ch_c.tick_t1   = tmr1_underflow;
  end

  rgt_timer u_tmr_b (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ch      (ch_b.tmr)
  );

  rgt_timer u_tmr_c (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ch      (ch_c.tmr)
  );

  always_comb begin
    st_next = st_reg;
    st_next.b_start = 1'b0;
    st_next.b_stop  = 1'b0;
    st_next.c_start = 1'b0;
    st_next.c_stop  = 1'b0;
    st_next.ready   = 1'b1;
    st_next.resp    = 1'b0;
    st_next.lfo_sync = {st_reg.lfo_sync[1:0], low_freq_oscillator};
    irq_clr = '0;
    // Anything above the map decodes as unmapped
    aidx = (haddr[31:10] == '0) ? haddr[9:2] : IDX_NONE;
    acc  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);

    // Data phase of a write; only the low byte carries register data
    if (st_reg.bus == BUS_WDATA) begin
      case (st_reg.widx)
        IDX_B_CTRL:  st_next.b_ctrl  = hwdata[7:0] & CTRL_WMASK;
        IDX_B_RL_HI: st_next.b_rl_hi = hwdata[7:0];
        IDX_B_RL_LO: st_next.b_rl_lo = hwdata[7:0];
        IDX_C_CTRL:  st_next.c_ctrl  = hwdata[7:0] & CTRL_WMASK;
        IDX_C_RL_HI: st_next.c_rl_hi = hwdata[7:0];
        IDX_C_RL_LO: st_next.c_rl_lo = hwdata[7:0];
        IDX_IRQ_EN:  st_next.irq_en  = hwdata[IRQ_W-1:0];
        IDX_IRQ_CLR: irq_clr         = hwdata[IRQ_W-1:0];
        IDX_CMD: begin
          st_next.b_start = hwdata[CMD_B_START];
          st_next.b_stop  = hwdata[CMD_B_STOP];
          st_next.c_start = hwdata[CMD_C_START];
          st_next.c_stop  = hwdata[CMD_C_STOP];
        end
        default: ;
      endcase
    end

    // Address phase; read data is prepared for the following data phase
    st_next.bus   = BUS_IDLE;
    st_next.rdata = 32'h0000_0000;
    if (acc && hwrite) begin
      st_next.bus  = BUS_WDATA;
      st_next.widx = aidx;
    end else if (acc) begin
      case (aidx)
        IDX_A_CNT_HI: st_next.rdata[7:0] = tmr_a_count[15:8];
        IDX_A_CNT_LO: st_next.rdata[7:0] = tmr_a_count[7:0];
        IDX_B_CTRL:   st_next.rdata[7:0] = st_reg.b_ctrl;
        IDX_B_RL_HI:  st_next.rdata[7:0] = st_reg.b_rl_hi;
        IDX_B_RL_LO:  st_next.rdata[7:0] = st_reg.b_rl_lo;
        IDX_B_CNT_HI: st_next.rdata[7:0] = ch_b.count[15:8];
        IDX_B_CNT_LO: st_next.rdata[7:0] = ch_b.count[7:0];
        IDX_C_CTRL:   st_next.rdata[7:0] = st_reg.c_ctrl;
        IDX_C_RL_HI:  st_next.rdata[7:0] = st_reg.c_rl_hi;
        IDX_C_RL_LO:  st_next.rdata[7:0] = st_reg.c_rl_lo;
        IDX_C_CNT_HI: st_next.rdata[7:0] = ch_c.count[15:8];
        IDX_C_CNT_LO: st_next.rdata[7:0] = ch_c.count[7:0];
        IDX_IRQ_STAT: st_next.rdata[IRQ_W-1:0] = st_reg.irq_st;
        IDX_IRQ_EN:   st_next.rdata[IRQ_W-1:0] = st_reg.irq_en;
        default:      st_next.rdata = 32'h0000_0000;
      endcase
    end

    // A new underflow beats a clear written in the same cycle
    irq_set = '0;
    irq_set[IRQ_B_BIT] = ch_b.uf;
    irq_set[IRQ_C_BIT] = ch_c.uf;
    st_next.irq_st = (st_reg.irq_st & ~irq_clr) | irq_set;
    st_next.irq    = |(st_next.irq_st & st_next.irq_en);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= TOP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata          = st_reg.rdata;
  assign hreadyout       = st_reg.ready;
  assign hresp           = st_reg.resp;
  assign irq             = st_reg.irq;
  assign tmr_b_underflow = ch_b.uf;
  assign tmr_c_underflow = ch_c.uf;

  // Helper: index of the read whose data phase is now on the bus
  logic [7:0] rd_idx_q;
  logic       rd_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_idx_q <= IDX_NONE;
      rd_q     <= 1'b0;
    end else begin
      rd_idx_q <= aidx;
      rd_q     <= acc && !hwrite;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RSVD_ZERO: assert property (
    st_reg.b_ctrl[6] == 1'b0 && st_reg.b_ctrl[2] == 1'b0 &&
    st_reg.c_ctrl[6] == 1'b0 && st_reg.c_ctrl[2] == 1'b0
  ) else $error("reserved control bit became set");
  AST_CNT_READ: assert property (
    acc && !hwrite && aidx == IDX_B_CNT_LO |=>
    hrdata == {24'h000000, $past(ch_b.count[7:0])}
  ) else $error("count low byte read mismatch");
  AST_RELOAD_WRITE_NO_DISTURB: assert property (
    st_reg.bus == BUS_WDATA && ch_b.running &&
    (st_reg.widx == IDX_B_RL_HI || st_reg.widx == IDX_B_RL_LO) |=>
    $stable(ch_b.count) || ch_b.count == $past(ch_b.count) - 16'h0001 ||
    ch_b.uf || $past(ch_b.sw_start || ch_b.tx_end || ch_b.lfo_rise)
  ) else $error("reload write changed a running count");
  AST_FLAG_STICKY: assert property (
    ch_b.uf |=> st_reg.irq_st[IRQ_B_BIT] ##1 st_reg.irq_st[IRQ_B_BIT] ||
    $past(irq_clr[IRQ_B_BIT])
  ) else $error("underflow flag not set or lost");
  AST_IRQ_LEVEL: assert property (
    irq == |(st_reg.irq_st & st_reg.irq_en)
  ) else $error("interrupt level does not match enabled status");
  AST_ZERO_WAIT: assert property (
    hreadyout && hresp == 1'b0
  ) else $error("slave stalled or answered with error");

  COV_B_UNDERFLOW: cover property (ch_b.uf ##1 irq);
  COV_C_TX_START: cover property (tx_end && ch_c.ctrl[5:4] == 2'b01
    ##1 ch_c.running);
  COV_CNT_READ: cover property (rd_q && rd_idx_q == IDX_C_CNT_HI);
  COV_RX_HALT: cover property (ch_b.running && rx_first4_bits
    ##1 !ch_b.running);
endmodule : rgt_timers_top

// file: rgt_timers_top_bench.sv
// rgt_timers_top_bench: self-checking bench for the reader timer block.
// Assumes a single hclk domain; the bench is the AHB-Lite master and also
// drives every transmit, receive, oscillator and tick source directly.
module rgt_timers_top_bench
  import rgt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int FAST = 0;
  localparam int TX   = 4;
  localparam int RX   = 5;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        tx_end;
  logic        rx_first4_bits;
  logic        low_freq_oscillator;
  logic        tick_13m56;
  logic        tick_212k;
  logic        tmr0_underflow;
  logic        tmr1_underflow;
  logic [15:0] tmr_a_count;
  logic        tmr_b_underflow;
  logic        tmr_c_underflow;
  logic        irq;
  logic [31:0] rd_q;
  logic        rdy_q;
  int          uf_b = 0;
  int          uf_c = 0;
  int          uf0;
  int          num_errors = 0;
  int          samples_checked = 0;
  logic [7:0]  base;

  rgt_timers_top rgt_timers_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tx_end(tx_end), .rx_first4_bits(rx_first4_bits),
    .low_freq_oscillator(low_freq_oscillator), .tick_13m56(tick_13m56),
    .tick_212k(tick_212k), .tmr0_underflow(tmr0_underflow),
    .tmr1_underflow(tmr1_underflow), .tmr_a_count(tmr_a_count),
    .tmr_b_underflow(tmr_b_underflow), .tmr_c_underflow(tmr_c_underflow),
    .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Edge samples avoid racing the registered outputs at the same edge
  always @(posedge hclk) begin
    rd_q <= hrdata;
    rdy_q <= hreadyout;
    if (tmr_b_underflow === 1'b1) begin
      uf_b <= uf_b + 1;
    end
    if (tmr_c_underflow === 1'b1) begin
      uf_c <= uf_c + 1;
    end
  end

  task automatic wrap_up;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
      num_errors++;
    end
  endtask : chk_bit

  task automatic step;
    @(posedge hclk);
    #1;
  endtask : step

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      step();
      n++;
    end while (rdy_q !== 1'b1 && n < 20);
    if (rdy_q !== 1'b1) begin
      $display("[FAIL] hreadyout expected 1 seen %b", rdy_q);
      num_errors++;
      wrap_up();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = rd_q;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    bus(1'b1, idx, {24'h0, d}, dummy);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] idx,
                        input logic [7:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    chk(what, {24'h0, exp}, v);
  endtask : rd_chk

  // Counts are read only while no reception is under way
  task automatic cnt_chk(input logic [7:0] b, input logic [15:0] exp);
    rd_chk("count high", b + 8'h3, exp[15:8]);
    rd_chk("count low", b + 8'h4, exp[7:0]);
  endtask : cnt_chk

  task automatic arm(input logic [7:0] b, input logic [7:0] ctrl,
                     input logic [15:0] rl);
    wr(b, ctrl);
    wr(b + 8'h1, rl[15:8]);
    wr(b + 8'h2, rl[7:0]);
  endtask : arm

  task automatic pulse(input int src);
    case (src)
      0: tick_13m56 <= 1'b1;
      1: tick_212k <= 1'b1;
      2: tmr0_underflow <= 1'b1;
      3: tmr1_underflow <= 1'b1;
      4: tx_end <= 1'b1;
      default: rx_first4_bits <= 1'b1;
    endcase
    step();
    {tick_13m56, tick_212k, tmr0_underflow} <= 3'h0;
    {tmr1_underflow, tx_end, rx_first4_bits} <= 3'h0;
    step();
  endtask : pulse

  task automatic ticks(input int n);
    repeat (n) pulse(FAST);
  endtask : ticks

  // The oscillator passes a synchroniser, so its start is polled, not timed
  task automatic osc_start(input logic [7:0] b, input logic [7:0] exp);
    logic [31:0] v;
    int          n;
    low_freq_oscillator <= 1'b0;
    repeat (4) step();
    low_freq_oscillator <= 1'b1;
    n = 0;
    do begin
      bus(1'b0, b + 8'h4, 32'h0, v);
      n++;
    end while (v[7:0] !== exp && n < 10);
    chk("oscillator start", {24'h0, exp}, v);
    if (v[7:0] !== exp) begin
      wrap_up();
    end
  endtask : osc_start

  initial begin
    hresetn <= 1'b0;
    {hsel, hwrite, tx_end, rx_first4_bits, low_freq_oscillator} <= 5'h0;
    {tick_13m56, tick_212k, tmr0_underflow, tmr1_underflow} <= 4'h0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hsize <= 3'h2;
    hwdata <= 32'h0;
    tmr_a_count <= 16'h5a3c;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    step();
    chk_bit("hresp", 1'b0, hresp);
    for (int t = 0; t < 2; t++) begin
      base = (t == 0) ? IDX_B_CTRL : IDX_C_CTRL;
      for (int i = 0; i < 5; i++) begin
        rd_chk("reset value", base + 8'(i), 8'h00);
      end
      wr(base, 8'hff);
      rd_chk("control reserved", base, 8'hbb);
      wr(base, 8'h00);
    end
    rd_chk("irq status reset", IDX_IRQ_STAT, 8'h00);
    rd_chk("irq enable reset", IDX_IRQ_EN, 8'h00);
    wr(8'h30, 8'hff);
    rd_chk("unmapped", 8'h30, 8'h00);
    wr(IDX_B_CNT_LO, 8'hff);
    rd_chk("count read only", IDX_B_CNT_LO, 8'h00);
    rd_chk("timer a high", IDX_A_CNT_HI, 8'h5a);
    rd_chk("timer a low", IDX_A_CNT_LO, 8'h3c);
    arm(IDX_B_CTRL, 8'h10, 16'h0002);
    wr(IDX_IRQ_EN, 8'h01);
    pulse(TX);
    cnt_chk(IDX_B_CTRL, 16'h0002);
    ticks(2);
    cnt_chk(IDX_B_CTRL, 16'h0000);
    chk("underflows", 32'd0, 32'(uf_b));
    ticks(1);
    chk("underflows", 32'd1, 32'(uf_b));
    chk_bit("irq", 1'b1, irq);
    rd_chk("irq status", IDX_IRQ_STAT, 8'h01);
    ticks(1);
    chk("one shot", 32'd1, 32'(uf_b));
    cnt_chk(IDX_B_CTRL, 16'h0000);
    wr(IDX_IRQ_EN, 8'h00);
    step();
    chk_bit("irq masked", 1'b0, irq);
    wr(IDX_IRQ_EN, 8'h01);
    step();
    chk_bit("irq unmasked", 1'b1, irq);
    wr(IDX_IRQ_CLR, 8'h01);
    step();
    chk_bit("irq cleared", 1'b0, irq);
    rd_chk("irq status cleared", IDX_IRQ_STAT, 8'h00);
    arm(IDX_B_CTRL, 8'h10, 16'h0103);
    pulse(TX);
    cnt_chk(IDX_B_CTRL, 16'h0103);
    wr(IDX_B_RL_LO, 8'h05);
    ticks(1);
    cnt_chk(IDX_B_CTRL, 16'h0102);
    pulse(TX);
    cnt_chk(IDX_B_CTRL, 16'h0105);
    wr(IDX_B_CTRL, 8'h90);
    pulse(RX);
    ticks(2);
    cnt_chk(IDX_B_CTRL, 16'h0105);
    wr(IDX_B_CTRL, 8'h10);
    pulse(TX);
    pulse(RX);
    ticks(1);
    cnt_chk(IDX_B_CTRL, 16'h0104);
    wr(IDX_CMD, 8'h02);
    arm(IDX_B_CTRL, 8'h18, 16'h0001);
    uf0 = uf_b;
    pulse(TX);
    ticks(4);
    chk("auto reload", 32'(uf0 + 2), 32'(uf_b));
    cnt_chk(IDX_B_CTRL, 16'h0001);
    wr(IDX_CMD, 8'h02);
    for (int t = 0; t < 2; t++) begin
      base = (t == 0) ? IDX_B_CTRL : IDX_C_CTRL;
      for (int s = 0; s < 4; s++) begin
        arm(base, 8'h10 | 8'(s), 16'h0003);
        pulse(TX);
        for (int src = 0; src < 4; src++) begin
          pulse(src);
        end
        cnt_chk(base, 16'h0002);
        // A tx_end restarts the other timer too, so both are stopped
        wr(IDX_CMD, 8'h0a);
      end
    end
    wr(IDX_CMD, 8'h04);
    cnt_chk(IDX_C_CTRL, 16'h0003);
    repeat (3) pulse(3);
    chk("underflows c", 32'd0, 32'(uf_c));
    pulse(3);
    chk("underflows c", 32'd1, 32'(uf_c));
    rd_chk("irq status c", IDX_IRQ_STAT, 8'h03);
    wr(IDX_CMD, 8'h08);
    arm(IDX_B_CTRL, 8'h80, 16'h0004);
    pulse(TX);
    ticks(1);
    cnt_chk(IDX_B_CTRL, 16'h0002);
    wr(IDX_B_CTRL, 8'ha0);
    osc_start(IDX_B_CTRL, 8'h04);
    pulse(RX);
    ticks(1);
    cnt_chk(IDX_B_CTRL, 16'h0003);
    uf0 = uf_b;
    ticks(4);
    chk("trim no underflow", 32'(uf0), 32'(uf_b));
    cnt_chk(IDX_B_CTRL, 16'h0000);
    wr(IDX_B_CTRL, 8'hb0);
    osc_start(IDX_B_CTRL, 8'h04);
    pulse(RX);
    ticks(5);
    chk("trim underflow", 32'(uf0 + 1), 32'(uf_b));
    wrap_up();
  end
endmodule : rgt_timers_top_bench

// file: rgt_tmr_if.sv
// rgt_tmr_if: control, events and state of one timer channel.
// Assumes all members are driven on hclk; events are one-cycle pulses.
interface rgt_tmr_if;
  logic [7:0]  ctrl;
  logic [15:0] reload;
  logic        sw_start;
  logic        sw_stop;
  logic        tx_end;
  logic        rx_first4;
  logic        lfo_rise;
  logic        tick_fast;
  logic        tick_slow;
  logic        tick_t0;
  logic        tick_t1;
  logic [15:0] count;
  logic        running;
  logic        uf;
  modport ctl (output ctrl, reload, sw_start, sw_stop, tx_end, rx_first4,
               lfo_rise, tick_fast, tick_slow, tick_t0, tick_t1,
               input count, running, uf);
  modport tmr (input ctrl, reload, sw_start, sw_stop, tx_end, rx_first4,
               lfo_rise, tick_fast, tick_slow, tick_t0, tick_t1,
               output count, running, uf);
endinterface : rgt_tmr_if
